// [bench/wvc_watch_checker.sv]
// Port checker for the watchpoint virtualization control block.
// Assumes binding onto wvc_watch_ctrl, single clock i_ref_clk.
`timescale 1ns/10ps
`default_nettype none
module wvc_watch_checker #(
    parameter N_PAIRS = 4,
    parameter SEL_W   = 2
) (
    input wire logic               i_ref_clk,
    input wire logic               i_srst,
    input wire logic               i_mv_valid,
    input wire logic               i_mv_guest,
    input wire logic               i_mv_write,
    input wire logic [N_PAIRS-1:0] i_match,
    input wire logic               o_mv_rvalid,
    input wire logic [31:0]        o_mv_rdata,
    input wire logic               o_guest_sensitive_trap,
    input wire logic               o_root_watch_exc,
    input wire logic               o_guest_watch_exc,
    input wire logic               o_guest_watch_en,
    input wire logic               o_guest_mode_eff,
    input wire logic               o_map_from_root
);
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    a_mode_map_excl: assert property (o_guest_mode_eff != o_map_from_root)
        else $error("guest mode and root map disagree");
    a_watch_en_mode: assert property (o_guest_watch_en |-> o_guest_mode_eff)
        else $error("guest watch on outside guest mode");
    a_guest_exc_cause: assert property (o_guest_watch_exc |-> $past(|i_match))
        else $error("guest watch exception without match");
    a_root_exc_cause: assert property (o_root_watch_exc |-> $past(|i_match))
        else $error("root watch exception without match");
    a_single_route: assert property ($onehot(i_match)
        |=> !(o_root_watch_exc && o_guest_watch_exc))
        else $error("one match raised both exceptions");
    a_trap_cause: assert property (o_guest_sensitive_trap
        |-> $past(i_mv_valid && i_mv_guest))
        else $error("trap without guest move");
    a_trap_read_zero: assert property ((o_guest_sensitive_trap && o_mv_rvalid)
        |-> o_mv_rdata == 32'h0)
        else $error("trapped read returned data");
    a_read_answer: assert property ((i_mv_valid && !i_mv_write) |=> o_mv_rvalid)
        else $error("read move not answered");
endmodule
bind wvc_watch_ctrl wvc_watch_checker #(.N_PAIRS(N_PAIRS), .SEL_W(SEL_W)) chk_u (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mv_valid(i_mv_valid),
    .i_mv_guest(i_mv_guest), .i_mv_write(i_mv_write), .i_match(i_match),
    .o_mv_rvalid(o_mv_rvalid), .o_mv_rdata(o_mv_rdata),
    .o_guest_sensitive_trap(o_guest_sensitive_trap),
    .o_root_watch_exc(o_root_watch_exc), .o_guest_watch_exc(o_guest_watch_exc),
    .o_guest_watch_en(o_guest_watch_en), .o_guest_mode_eff(o_guest_mode_eff),
    .o_map_from_root(o_map_from_root));
`default_nettype wire

// [bench/wvc_watch_ctrl_bench.sv]
// Self-checking bench for the watchpoint virtualization control block.
// Assumes the checker is bound separately; drives all ports itself.
`timescale 1ns/10ps
`include "wvc_defines.vh"
`default_nettype none
module wvc_watch_ctrl_bench;
    typedef struct packed {
        logic [2:0]  gwh;
        logic [1:0]  p;
        logic [31:0] d;
        logic        rv;
        logic [31:0] rdv;
        logic        tr;
    } wvc_row_t;
    logic        clk, srst, awvalid, wvalid, bready, arvalid, rready;
    logic        mv_valid, mv_guest, mv_write, mv_high;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, mv_wdata, rd;
    logic [3:0]  wstrb, match;
    logic [1:0]  mv_pair, rsp;
    wire         awready, wready, bvalid, arready, rvalid, mv_rvalid, trap;
    wire         rexc, gexc, gen, gmode, mroot, irq;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata, mv_rdata;
    int          bad_count = 0;
    int          checks = 0;
    // Guest/write/high, pair, data, read valid, read data, trap
    wvc_row_t rows[13] = '{
        {3'b011, 2'h0, 32'h1, 1'b0, 32'h0, 1'b0},
        {3'b001, 2'h0, 32'h0, 1'b1, 32'h0, 1'b0},
        {3'b100, 2'h0, 32'h0, 1'b1, 32'h0, 1'b1},
        {3'b010, 2'h0, 32'h12345678, 1'b0, 32'h0, 1'b0},
        {3'b110, 2'h0, 32'hdeadbeef, 1'b0, 32'h0, 1'b1},
        {3'b000, 2'h0, 32'h0, 1'b1, 32'h12345678, 1'b0},
        {3'b011, 2'h1, 32'h3, 1'b0, 32'h0, 1'b0},
        {3'b001, 2'h1, 32'h0, 1'b1, 32'h2, 1'b0},
        {3'b101, 2'h1, 32'h0, 1'b1, 32'h0, 1'b0},
        {3'b110, 2'h1, 32'hab0, 1'b0, 32'h0, 1'b0},
        {3'b100, 2'h1, 32'h0, 1'b1, 32'hab0, 1'b0},
        {3'b111, 2'h1, 32'h0, 1'b0, 32'h0, 1'b0},
        {3'b001, 2'h1, 32'h0, 1'b1, 32'h2, 1'b0}};

    wvc_watch_ctrl #(.N_PAIRS(4), .SEL_W(2)) dut_u (
        .i_ref_clk(clk), .i_srst(srst),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
        .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
        .i_mv_valid(mv_valid), .i_mv_guest(mv_guest), .i_mv_write(mv_write),
        .i_mv_high(mv_high), .i_mv_pair(mv_pair), .i_mv_wdata(mv_wdata),
        .o_mv_rvalid(mv_rvalid), .o_mv_rdata(mv_rdata),
        .o_guest_sensitive_trap(trap), .i_match(match),
        .o_root_watch_exc(rexc), .o_guest_watch_exc(gexc),
        .o_guest_watch_en(gen), .o_guest_mode_eff(gmode),
        .o_map_from_root(mroot), .o_irq(irq));

    always #2 clk = ~clk;

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic close_out;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n > 64) begin
            bad_count++;
            close_out;
        end
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            tmo(n);
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
        #1;
    endtask
    task automatic axi_rd(input logic [11:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            tmo(n);
        end while (!rvalid);
        rd = rdata; rsp = rresp; rready <= 1'b0;
        #1;
    endtask
    task automatic mv(input wvc_row_t r);
        @(posedge clk);
        {mv_guest, mv_write, mv_high} <= r.gwh;
        mv_valid <= 1'b1; mv_pair <= r.p; mv_wdata <= r.d;
        @(posedge clk);
        mv_valid <= 1'b0;
        #1;
        chk(mv_rvalid, r.rv);
        chk(trap, r.tr);
        if (r.rv) chk(mv_rdata, r.rdv);
    endtask
    task automatic hit(input logic [3:0] m, input logic er, input logic eg);
        @(posedge clk);
        match <= m;
        @(posedge clk);
        match <= 4'h0;
        #1;
        chk(rexc, er);
        chk(gexc, eg);
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        {clk, awvalid, wvalid, bready, arvalid, rready, mv_valid} = 7'h0;
        {mv_guest, mv_write, mv_high, mv_pair, match} = 9'h0;
        {awaddr, araddr, wdata, mv_wdata} = 88'h0;
        wstrb = 4'hf;
        srst = 1'b1;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        #1;
        chk(mroot, 1'b1);
        chk(gmode, 1'b0);
        axi_rd(`WVC_OFF_CTRL);
        chk(rd, 32'h3);
        foreach (rows[i]) mv(rows[i]);
        axi_wr(`WVC_OFF_CTRL, 32'hb);
        chk(rsp, `WVC_RESP_OKAY);
        chk(gen, 1'b1);
        chk(gmode, 1'b1);
        chk(mroot, 1'b0);
        hit(4'h1, 1'b1, 1'b0);
        hit(4'h2, 1'b0, 1'b1);
        hit(4'h3, 1'b1, 1'b1);
        axi_wr(`WVC_OFF_CTRL, 32'h1b);
        chk(gen, 1'b0);
        hit(4'h2, 1'b0, 1'b0);
        axi_wr(`WVC_OFF_CTRL, 32'h4b);
        chk(gmode, 1'b0);
        chk(mroot, 1'b1);
        mv({3'b100, 2'h1, 32'h0, 1'b1, 32'hab0, 1'b0});
        chk(irq, 1'b0);
        axi_wr(`WVC_OFF_IRQ_MASK, 32'h7);
        chk(irq, 1'b1);
        axi_rd(`WVC_OFF_IRQ_STAT);
        chk(rd, 32'h7);
        chk(irq, 1'b0);
        hit(4'h1, 1'b1, 1'b0);
        chk(irq, 1'b1);
        axi_rd(`WVC_OFF_IRQ_STAT);
        chk(rd, 32'h1);
        axi_wr(`WVC_OFF_CTRL, 32'h9);
        axi_rd(`WVC_OFF_CTRL);
        chk(rd, 32'h9);
        mv({3'b100, 2'h1, 32'h0, 1'b1, 32'h0, 1'b0});
        hit(4'h2, 1'b1, 1'b0);
        axi_wr(`WVC_OFF_CTRL, 32'h2);
        mv({3'b010, 2'h0, 32'hffff, 1'b0, 32'h0, 1'b0});
        axi_wr(`WVC_OFF_CTRL, 32'h3);
        mv({3'b000, 2'h0, 32'h0, 1'b1, 32'h12345678, 1'b0});
        for (int p = 0; p < 4; p++) mv({3'b011, p[1:0], 32'h2, 1'b0, 32'h0, 1'b0});
        axi_wr(`WVC_OFF_CTRL, 32'hb);
        hit(4'hf, 1'b0, 1'b1);
        axi_wr(12'h100, 32'h0);
        chk(rsp, `WVC_RESP_SLVERR);
        axi_rd(12'h100);
        chk(rsp, `WVC_RESP_SLVERR);
        chk(rd, 32'h0);
        close_out;
    end
endmodule
`default_nettype wire

// [common/wvc_defines.vh]
// Constants for the watchpoint virtualization control block.
// Assumes inclusion by bare name from design files.
`ifndef WVC_DEFINES_VH
`define WVC_DEFINES_VH

// ****************************************************************
// AXI4-Lite register offsets
// ****************************************************************
`define WVC_OFF_CTRL      12'h000
`define WVC_OFF_STATUS    12'h004
`define WVC_OFF_IRQ_STAT  12'h008
`define WVC_OFF_IRQ_MASK  12'h00c
`define WVC_OFF_SEL       12'h010
`define WVC_OFF_HIGH      12'h014
`define WVC_OFF_LOW       12'h018

// ****************************************************************
// Control register fields
// ****************************************************************
`define WVC_CTRL_ROOT_WR     0
`define WVC_CTRL_GUEST_WR    1
`define WVC_CTRL_GPA_IMPL    2
`define WVC_CTRL_GUEST_MODE  3
`define WVC_CTRL_EXC_LVL     4
`define WVC_CTRL_ERR_LVL     5
`define WVC_CTRL_DEBUG       6
`define WVC_CTRL_RESET       32'h0000_0003

// ****************************************************************
// Watch high register fields
// ****************************************************************
`define WVC_WM_LO            0
`define WVC_WM_HI            1
`define WVC_HIGH_MASK        32'hffff_fffc

// ****************************************************************
// Watch owner field encodings
// ****************************************************************
`define WVC_WM_ROOT_RVA      2'h0
`define WVC_WM_ROOT_GPA      2'h1
`define WVC_WM_GUEST_GVA     2'h2
`define WVC_WM_RESERVED      2'h3

// ****************************************************************
// Interrupt event bits
// ****************************************************************
`define WVC_EV_ROOT_WATCH    0
`define WVC_EV_GUEST_WATCH   1
`define WVC_EV_SENS_TRAP     2
`define WVC_NUM_EV           3

// ****************************************************************
// AXI responses
// ****************************************************************
`define WVC_RESP_OKAY        2'h0
`define WVC_RESP_SLVERR      2'h2

`endif

// [hdl/wvc_watch_ctrl.v]
// Watchpoint virtualization control: pair ownership, guest move filtering,
// owner-field coercion, exception routing and guest watch gating.
// Assumes core-side strobes on i_ref_clk; AXI4-Lite master for registers.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "wvc_defines.vh"
`default_nettype none

module wvc_watch_ctrl #(
    parameter N_PAIRS = 4,
    parameter SEL_W   = 2
) (
    input  wire              i_ref_clk,
    input  wire              i_srst,
    // AXI4-Lite slave
    input  wire [11:0]       i_awaddr,
    input  wire              i_awvalid,
    output reg               o_awready,
    input  wire [31:0]       i_wdata,
    input  wire [3:0]        i_wstrb,
    input  wire              i_wvalid,
    output reg               o_wready,
    output reg  [1:0]        o_bresp,
    output reg               o_bvalid,
    input  wire              i_bready,
    input  wire [11:0]       i_araddr,
    input  wire              i_arvalid,
    output reg               o_arready,
    output reg  [31:0]       o_rdata,
    output reg  [1:0]        o_rresp,
    output reg               o_rvalid,
    input  wire              i_rready,
    // Core move port
    input  wire              i_mv_valid,
    input  wire              i_mv_guest,
    input  wire              i_mv_write,
    input  wire              i_mv_high,
    input  wire [SEL_W-1:0]  i_mv_pair,
    input  wire [31:0]       i_mv_wdata,
    output reg               o_mv_rvalid,
    output reg  [31:0]       o_mv_rdata,
    output reg               o_guest_sensitive_trap,
    // Address match from comparators, one bit per pair
    input  wire [N_PAIRS-1:0] i_match,
    output reg               o_root_watch_exc,
    output reg               o_guest_watch_exc,
    output reg               o_guest_watch_en,
    output reg               o_guest_mode_eff,
    output reg               o_map_from_root,
    output reg               o_irq
);

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [31:0] ctrl_q;
    reg  [31:0] watch_high_reg [0:N_PAIRS-1];
    reg  [31:0] watch_low_reg  [0:N_PAIRS-1];
    reg  [SEL_W-1:0] sel_q;
    reg  [`WVC_NUM_EV-1:0] irq_stat_q;
    reg  [`WVC_NUM_EV-1:0] irq_mask_q;
    reg  [11:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;
    reg         aw_have_q;
    reg         w_have_q;
    integer     k;
    integer     m;

    wire root_wr_present  = ctrl_q[`WVC_CTRL_ROOT_WR];
    wire guest_wr_present = ctrl_q[`WVC_CTRL_GUEST_WR];
    wire gpa_impl         = ctrl_q[`WVC_CTRL_GPA_IMPL];
    wire debug_mode_flag  = ctrl_q[`WVC_CTRL_DEBUG];
    // Debug forces guest mode off
    wire guest_mode_flag  = ctrl_q[`WVC_CTRL_GUEST_MODE] & ~debug_mode_flag;
    wire exception_level_flag = ctrl_q[`WVC_CTRL_EXC_LVL];
    wire error_level_flag     = ctrl_q[`WVC_CTRL_ERR_LVL];
    wire guest_watch_on = guest_mode_flag & ~exception_level_flag
                          & ~error_level_flag & ~debug_mode_flag;

    // ****************************************************************
    // Owner field coercion
    // ****************************************************************
    function [1:0] wvc_coerce;
        input [1:0] wm;
        input       guest_physical_addr;
        input       gwr;
        begin
            wvc_coerce = wm;
            if (!gwr)
                wvc_coerce = {1'b0, wm[0] & guest_physical_addr};
            else if (wm == `WVC_WM_RESERVED)
                wvc_coerce = `WVC_WM_GUEST_GVA;
            else if (wm == `WVC_WM_ROOT_GPA && !guest_physical_addr)
                wvc_coerce = `WVC_WM_ROOT_RVA;
        end
    endfunction

    // ****************************************************************
    // Guest move decode
    // ****************************************************************
    wire [1:0] pair_wm = watch_high_reg[i_mv_pair][`WVC_WM_HI:`WVC_WM_LO];
    wire guest_owns    = pair_wm[`WVC_WM_HI];
    wire g_mv   = i_mv_valid & i_mv_guest;
    wire r_mv   = i_mv_valid & ~i_mv_guest & root_wr_present;
    wire g_trap = g_mv & guest_wr_present & ~guest_owns;
    // Guest owned pair: direct access, no trap
    wire g_ok   = g_mv & guest_wr_present & guest_owns;
    wire [31:0] pair_val = i_mv_high ? watch_high_reg[i_mv_pair]
                                     : watch_low_reg[i_mv_pair];

    // ****************************************************************
    // AXI4-Lite write
    // ****************************************************************
    wire do_wr = aw_have_q & w_have_q & ~o_bvalid;
    wire do_rd = i_arvalid & o_arready;
    wire rd_stat = do_rd & (i_araddr == `WVC_OFF_IRQ_STAT);

    function [31:0] wvc_merge;
        input [31:0] old;
        input [31:0] nv;
        input [3:0]  st;
        integer b;
        begin
            wvc_merge = old;
            for (b = 0; b < 4; b = b + 1)
                if (st[b])
                    wvc_merge[b*8 +: 8] = nv[b*8 +: 8];
        end
    endfunction

    wire [31:0] wr_val = wvc_merge(
        (awaddr_q == `WVC_OFF_CTRL)     ? ctrl_q :
        (awaddr_q == `WVC_OFF_HIGH)     ? watch_high_reg[sel_q] :
        (awaddr_q == `WVC_OFF_LOW)      ? watch_low_reg[sel_q] :
        32'h0000_0000, wdata_q, wstrb_q);

    wire wr_known = (awaddr_q == `WVC_OFF_CTRL) || (awaddr_q == `WVC_OFF_IRQ_MASK) ||
                    (awaddr_q == `WVC_OFF_SEL) || (awaddr_q == `WVC_OFF_HIGH) ||
                    (awaddr_q == `WVC_OFF_LOW);

    // ****************************************************************
    // Events
    // ****************************************************************
    reg [N_PAIRS-1:0] root_hit;
    reg [N_PAIRS-1:0] guest_hit;
    always @* begin
        for (k = 0; k < N_PAIRS; k = k + 1) begin
            // Guest pairs watch only when guest watching enabled
            guest_hit[k] = i_match[k] & guest_wr_present
                           & watch_high_reg[k][`WVC_WM_HI] & guest_watch_on;
            root_hit[k]  = i_match[k] & root_wr_present
                           & ~(guest_wr_present & watch_high_reg[k][`WVC_WM_HI]);
        end
    end
    wire [`WVC_NUM_EV-1:0] ev = {g_trap, |guest_hit, |root_hit};

    always @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_q     <= `WVC_CTRL_RESET;
            sel_q      <= {SEL_W{1'b0}};
            irq_stat_q <= {`WVC_NUM_EV{1'b0}};
            irq_mask_q <= {`WVC_NUM_EV{1'b0}};
            awaddr_q   <= 12'h000;
            wdata_q    <= 32'h0000_0000;
            wstrb_q    <= 4'h0;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            o_awready  <= 1'b0;
            o_wready   <= 1'b0;
            o_bvalid   <= 1'b0;
            o_bresp    <= `WVC_RESP_OKAY;
            o_arready  <= 1'b0;
            o_rvalid   <= 1'b0;
            o_rdata    <= 32'h0000_0000;
            o_rresp    <= `WVC_RESP_OKAY;
            o_mv_rvalid <= 1'b0;
            o_mv_rdata  <= 32'h0000_0000;
            o_guest_sensitive_trap <= 1'b0;
            o_root_watch_exc  <= 1'b0;
            o_guest_watch_exc <= 1'b0;
            o_guest_watch_en  <= 1'b0;
            o_guest_mode_eff  <= 1'b0;
            o_map_from_root   <= 1'b1;
            o_irq             <= 1'b0;
            for (m = 0; m < N_PAIRS; m = m + 1) begin
                watch_high_reg[m] <= 32'h0000_0000;
                watch_low_reg[m]  <= 32'h0000_0000;
            end
        end else begin
            // Address/data capture, either order
            o_awready <= ~aw_have_q;
            o_wready  <= ~w_have_q;
            if (i_awvalid & o_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid & o_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (o_bvalid & i_bready)
                o_bvalid <= 1'b0;
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= wr_known ? `WVC_RESP_OKAY : `WVC_RESP_SLVERR;
                case (awaddr_q)
                    // Guest bit is root-writable
                    `WVC_OFF_CTRL: ctrl_q <= {25'h0000000, wr_val[6:0]};
                    `WVC_OFF_IRQ_MASK: irq_mask_q <= wdata_q[`WVC_NUM_EV-1:0];
                    `WVC_OFF_SEL: sel_q <= wdata_q[SEL_W-1:0];
                    `WVC_OFF_HIGH: begin
                        if (root_wr_present)
                            watch_high_reg[sel_q] <= {wr_val[31:2],
                                wvc_coerce(wr_val[1:0], gpa_impl, guest_wr_present)};
                    end
                    `WVC_OFF_LOW: begin
                        if (root_wr_present)
                            watch_low_reg[sel_q] <= wr_val;
                    end
                    default: begin
                    end
                endcase
            end
            // Read channel
            o_arready <= ~o_rvalid;
            if (o_rvalid & i_rready)
                o_rvalid <= 1'b0;
            if (do_rd) begin
                o_arready <= 1'b0;
                o_rvalid  <= 1'b1;
                o_rresp   <= `WVC_RESP_OKAY;
                case (i_araddr)
                    `WVC_OFF_CTRL:     o_rdata <= ctrl_q;
                    `WVC_OFF_STATUS:   o_rdata <= {28'h0000000, guest_owns_any(1'b0),
                                          guest_watch_on, guest_mode_flag, debug_mode_flag};
                    `WVC_OFF_IRQ_STAT: o_rdata <= {29'h0000000, irq_stat_q};
                    `WVC_OFF_IRQ_MASK: o_rdata <= {29'h0000000, irq_mask_q};
                    `WVC_OFF_SEL:      o_rdata <= {{(32-SEL_W){1'b0}}, sel_q};
                    `WVC_OFF_HIGH:     o_rdata <= root_wr_present ? watch_high_reg[sel_q]
                                                                  : 32'h0000_0000;
                    `WVC_OFF_LOW:      o_rdata <= root_wr_present ? watch_low_reg[sel_q]
                                                                  : 32'h0000_0000;
                    default: begin
                        o_rdata <= 32'h0000_0000;
                        o_rresp <= `WVC_RESP_SLVERR;
                    end
                endcase
            end
            // Sticky events: set wins over read clear
            irq_stat_q <= (rd_stat ? {`WVC_NUM_EV{1'b0}} : irq_stat_q) | ev;
            o_irq <= |(((rd_stat ? {`WVC_NUM_EV{1'b0}} : irq_stat_q) | ev) & irq_mask_q);

            // Core moves
            o_mv_rvalid <= i_mv_valid & ~i_mv_write;
            o_mv_rdata  <= 32'h0000_0000;
            o_guest_sensitive_trap <= g_trap;
            if (r_mv) begin
                if (i_mv_write) begin
                    if (i_mv_high)
                        watch_high_reg[i_mv_pair] <= {i_mv_wdata[31:2],
                            wvc_coerce(i_mv_wdata[1:0], gpa_impl, guest_wr_present)};
                    else
                        watch_low_reg[i_mv_pair] <= i_mv_wdata;
                end else
                    o_mv_rdata <= pair_val;
            end else if (g_ok) begin
                // Guest moves never touch the owner field
                if (i_mv_write) begin
                    if (i_mv_high)
                        watch_high_reg[i_mv_pair] <= (i_mv_wdata & `WVC_HIGH_MASK)
                            | (watch_high_reg[i_mv_pair] & ~`WVC_HIGH_MASK);
                    else
                        watch_low_reg[i_mv_pair] <= i_mv_wdata;
                end else
                    o_mv_rdata <= i_mv_high ? (pair_val & `WVC_HIGH_MASK) : pair_val;
            end
            // Guest with no guest watch: write dropped, read zero

            o_root_watch_exc  <= |root_hit;
            o_guest_watch_exc <= |guest_hit;
            o_guest_watch_en  <= guest_watch_on;
            o_guest_mode_eff  <= guest_mode_flag;
            o_map_from_root   <= debug_mode_flag | ~guest_mode_flag;
        end
    end

    function guest_owns_any;
        input dummy;
        integer j;
        begin
            guest_owns_any = dummy;
            for (j = 0; j < N_PAIRS; j = j + 1)
                guest_owns_any = guest_owns_any | watch_high_reg[j][`WVC_WM_HI];
        end
    endfunction

endmodule

`default_nettype wire
